// *** rtl/pcsr_defines.svh ***
/*
  Register offsets, field positions, reset values and timing counts
  of the transceiver control and status register bank.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef PCSR_DEFINES_SVH
`define PCSR_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCSR_OFF_CONTROL 8'hB4
`define PCSR_OFF_STATUS 8'hB8
`define PCSR_OFF_IDENT_HIGH 8'hBC
`define PCSR_OFF_IDENT_LOW 8'hC0
`define PCSR_OFF_IRQ_STATUS 8'hE0
`define PCSR_OFF_IRQ_MASK 8'hE4

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define PCSR_CTL_SOFT_RESET 15
`define PCSR_CTL_LOOPBACK 14
`define PCSR_CTL_SPEED 13
`define PCSR_CTL_AN_ENABLE 12
`define PCSR_CTL_POWER_DOWN 11
`define PCSR_CTL_AN_RESTART 9
`define PCSR_CTL_DUPLEX 8
`define PCSR_CTL_COL_TEST 7

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define PCSR_STS_T4_ABLE 15
`define PCSR_STS_FAST_FD 14
`define PCSR_STS_FAST_HD 13
`define PCSR_STS_SLOW_FD 12
`define PCSR_STS_SLOW_HD 11
`define PCSR_STS_AN_DONE 5
`define PCSR_STS_REMOTE_FAULT 4
`define PCSR_STS_AN_ABLE 3
`define PCSR_STS_LINK 2
`define PCSR_STS_JABBER 1
`define PCSR_STS_EXT_ABLE 0

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define PCSR_CTL_RESET 16'h3000
`define PCSR_CTL_WMASK 16'hFB80
`define PCSR_IRQ_WIDTH 4
`define PCSR_IRQ_MASK_RESET 4'h0

// ----------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------
`define PCSR_IRQ_AN_DONE 0
`define PCSR_IRQ_REMOTE_FAULT 1
`define PCSR_IRQ_LINK_FAIL 2
`define PCSR_IRQ_JABBER 3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PCSR_CLK_MHZ 125
`define PCSR_XCVR_RESET_NS 1000
`define PCSR_XCVR_RESET_CYCLES ((`PCSR_XCVR_RESET_NS * `PCSR_CLK_MHZ + 999) / 1000)

`endif

// *** rtl/pcsr_pkg.sv ***
/*
  Types shared by the transceiver register bank.
  Assumes pcsr_defines.svh on the include path.
*/
`include "pcsr_defines.svh"

package pcsr_pkg;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } pcsr_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pcsr_apb_rsp_t;

  // Controls presented to the transceiver datapath
  typedef struct packed {
    logic softReset;
    logic loopbackSel;
    logic speed100;
    logic autonegEnable;
    logic powerDown;
    logic autonegRestart;
    logic fullDuplex;
    logic collisionTestEn;
  } pcsr_xcvr_ctl_t;

  // Raw conditions reported by the transceiver datapath
  typedef struct packed {
    logic resetDone;
    logic autonegRestarted;
    logic autonegDone;
    logic remoteFault;
    logic linkUp;
    logic jabber;
  } pcsr_xcvr_sts_t;

endpackage

// *** rtl/pcsr_reset_pulse.sv ***
/*
  Stretches the transceiver soft reset so it lasts a minimum time.
  Assumes one clock; start is a one-cycle pulse.
*/
module pcsr_reset_pulse #(
  parameter int unsigned MIN_CYCLES = 125
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  output logic busy
);

  logic [15:0] count_r;

  // ----------------------------------------------------------------
  // Minimum hold counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count_r <= 16'h0000;
    end
    else if (start)
    begin
      count_r <= 16'(MIN_CYCLES);
    end
    else if (count_r != 16'h0000)
    begin
      count_r <= count_r - 16'h0001;
    end
  end

  assign busy = (count_r != 16'h0000);

endmodule

// *** rtl/pcsr_top.sv ***
/*
  Control, status and identifier registers of an integrated Ethernet
  transceiver, reached over APB with 32-bit words; upper halves read 0.
  Assumes the transceiver datapath drives xcvrSts synchronous to clk.
*/
// The APB register port is this design's own decision.
`include "pcsr_defines.svh"

module pcsr_top #(
  // Arbitrary identifier values
  parameter logic [15:0] OUI_PART_ONE = 16'h0A5A,
  parameter logic [5:0] OUI_PART_TWO = 6'h15,
  parameter logic [5:0] MODEL_NUMBER = 6'h2A,
  parameter logic [3:0] REVISION_NUMBER = 4'h3,
  parameter int unsigned XCVR_RESET_CYCLES = `PCSR_XCVR_RESET_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire pcsr_pkg::pcsr_apb_req_t apbReq,
  output pcsr_pkg::pcsr_apb_rsp_t apbRsp,
  output pcsr_pkg::pcsr_xcvr_ctl_t xcvrCtl,
  input wire pcsr_pkg::pcsr_xcvr_sts_t xcvrSts,
  output logic irq
);
  import pcsr_pkg::*;

  function automatic logic [31:0] widen(input logic [15:0] half);
    widen = {16'h0000, half};
  endfunction

  logic [15:0] control_r;
  logic remoteFault_r;
  logic linkLatched_r;
  logic jabber_r;
  logic [`PCSR_IRQ_WIDTH-1:0] irqStatus_r;
  logic [`PCSR_IRQ_WIDTH-1:0] irqMask_r;
  logic [31:0] rdata_r;
  logic resetStart_r;
  logic resetBusy;
  logic resetSeen_r;
  logic autonegDonePrev_r;
  logic linkPrev_r;
  logic access;
  logic wrAccess;
  logic rdAccess;
  logic statusRead;
  logic ctlWrite;
  logic mapped;
  logic [15:0] statusWord;
  logic [15:0] identLow;
  logic [`PCSR_IRQ_WIDTH-1:0] irqEvents;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign access = apbReq.psel && apbReq.penable;
  assign wrAccess = access && apbReq.pwrite;
  assign rdAccess = access && !apbReq.pwrite;
  assign ctlWrite = wrAccess && (apbReq.paddr == `PCSR_OFF_CONTROL);
  assign statusRead = rdAccess && (apbReq.paddr == `PCSR_OFF_STATUS);

  always_comb
  begin
    unique case (apbReq.paddr)
      `PCSR_OFF_CONTROL,
      `PCSR_OFF_STATUS,
      `PCSR_OFF_IDENT_HIGH,
      `PCSR_OFF_IDENT_LOW,
      `PCSR_OFF_IRQ_STATUS,
      `PCSR_OFF_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = access && !mapped;
  assign apbRsp.prdata = rdata_r;

  // ----------------------------------------------------------------
  // Transceiver reset stretcher
  // ----------------------------------------------------------------
  pcsr_reset_pulse #(
    .MIN_CYCLES(XCVR_RESET_CYCLES)
  ) u_reset_pulse (
    .clk(clk),
    .reset(reset),
    .start(resetStart_r),
    .busy(resetBusy)
  );

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      control_r <= `PCSR_CTL_RESET;
      resetStart_r <= 1'b0;
      resetSeen_r <= 1'b0;
    end
    else
    begin
      resetStart_r <= 1'b0;
      if (ctlWrite)
      begin
        control_r <= apbReq.pwdata[15:0] & `PCSR_CTL_WMASK;
        resetStart_r <= apbReq.pwdata[`PCSR_CTL_SOFT_RESET];
        resetSeen_r <= 1'b0;
      end
      else
      begin
        if (xcvrSts.resetDone)
        begin
          resetSeen_r <= 1'b1;
        end
        if (control_r[`PCSR_CTL_SOFT_RESET] && !resetStart_r && !resetBusy
            && (resetSeen_r || xcvrSts.resetDone))
        begin
          control_r[`PCSR_CTL_SOFT_RESET] <= 1'b0;
        end
        if (control_r[`PCSR_CTL_AN_RESTART] && xcvrSts.autonegRestarted)
        begin
          control_r[`PCSR_CTL_AN_RESTART] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Controls to the transceiver
  // ----------------------------------------------------------------
  always_comb
  begin
    xcvrCtl.softReset = control_r[`PCSR_CTL_SOFT_RESET] || resetBusy;
    xcvrCtl.loopbackSel = control_r[`PCSR_CTL_LOOPBACK];
    xcvrCtl.speed100 = control_r[`PCSR_CTL_SPEED] && !control_r[`PCSR_CTL_AN_ENABLE];
    xcvrCtl.autonegEnable = control_r[`PCSR_CTL_AN_ENABLE];
    xcvrCtl.powerDown = control_r[`PCSR_CTL_POWER_DOWN];
    xcvrCtl.autonegRestart = control_r[`PCSR_CTL_AN_RESTART];
    xcvrCtl.fullDuplex = control_r[`PCSR_CTL_DUPLEX] && !control_r[`PCSR_CTL_AN_ENABLE];
    xcvrCtl.collisionTestEn = control_r[`PCSR_CTL_COL_TEST];
  end

  // ----------------------------------------------------------------
  // Latched status bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      remoteFault_r <= 1'b0;
      linkLatched_r <= 1'b0;
      jabber_r <= 1'b0;
    end
    else
    begin
      if (xcvrSts.remoteFault)
      begin
        remoteFault_r <= 1'b1;
      end
      else if (statusRead)
      begin
        remoteFault_r <= 1'b0;
      end
      if (!xcvrSts.linkUp)
      begin
        linkLatched_r <= 1'b0;
      end
      else if (statusRead)
      begin
        linkLatched_r <= 1'b1;
      end
      if (xcvrSts.jabber && !xcvrCtl.speed100)
      begin
        jabber_r <= 1'b1;
      end
      else if (statusRead)
      begin
        jabber_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  always_comb
  begin
    statusWord = 16'h0000;
    statusWord[`PCSR_STS_T4_ABLE] = 1'b0;
    statusWord[`PCSR_STS_FAST_FD] = 1'b1;
    statusWord[`PCSR_STS_FAST_HD] = 1'b1;
    statusWord[`PCSR_STS_SLOW_FD] = 1'b1;
    statusWord[`PCSR_STS_SLOW_HD] = 1'b1;
    statusWord[`PCSR_STS_AN_DONE] = xcvrSts.autonegDone;
    statusWord[`PCSR_STS_REMOTE_FAULT] = remoteFault_r;
    statusWord[`PCSR_STS_AN_ABLE] = 1'b1;
    statusWord[`PCSR_STS_EXT_ABLE] = 1'b1;
    statusWord[`PCSR_STS_LINK] = linkLatched_r;
    statusWord[`PCSR_STS_JABBER] = jabber_r;
  end

  assign identLow = {OUI_PART_TWO, MODEL_NUMBER, REVISION_NUMBER};

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_r <= 32'h00000000;
    end
    else if (apbReq.psel && !apbReq.penable && !apbReq.pwrite)
    begin
      unique case (apbReq.paddr)
        `PCSR_OFF_CONTROL: rdata_r <= widen(control_r);
        `PCSR_OFF_STATUS: rdata_r <= widen(statusWord);
        `PCSR_OFF_IDENT_HIGH: rdata_r <= widen(OUI_PART_ONE);
        `PCSR_OFF_IDENT_LOW: rdata_r <= widen(identLow);
        `PCSR_OFF_IRQ_STATUS: rdata_r <= {28'h0000000, irqStatus_r};
        `PCSR_OFF_IRQ_MASK: rdata_r <= {28'h0000000, irqMask_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      autonegDonePrev_r <= 1'b0;
      linkPrev_r <= 1'b0;
    end
    else
    begin
      autonegDonePrev_r <= xcvrSts.autonegDone;
      linkPrev_r <= xcvrSts.linkUp;
    end
  end

  always_comb
  begin
    irqEvents = '0;
    irqEvents[`PCSR_IRQ_AN_DONE] = xcvrSts.autonegDone && !autonegDonePrev_r;
    irqEvents[`PCSR_IRQ_REMOTE_FAULT] = xcvrSts.remoteFault && !remoteFault_r;
    irqEvents[`PCSR_IRQ_LINK_FAIL] = !xcvrSts.linkUp && linkPrev_r;
    irqEvents[`PCSR_IRQ_JABBER] = xcvrSts.jabber && !xcvrCtl.speed100 && !jabber_r;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irqStatus_r <= '0;
      irqMask_r <= `PCSR_IRQ_MASK_RESET;
    end
    else
    begin
      if (wrAccess && (apbReq.paddr == `PCSR_OFF_IRQ_MASK))
      begin
        irqMask_r <= apbReq.pwdata[`PCSR_IRQ_WIDTH-1:0];
      end
      if (wrAccess && (apbReq.paddr == `PCSR_OFF_IRQ_STATUS))
      begin
        irqStatus_r <= (irqStatus_r & ~apbReq.pwdata[`PCSR_IRQ_WIDTH-1:0]) | irqEvents;
      end
      else
      begin
        irqStatus_r <= irqStatus_r | irqEvents;
      end
    end
  end

  assign irq = |(irqStatus_r & irqMask_r);

endmodule

// *** dv/pcsr_top_asserts.sv ***
/*
  Port checker for pcsr_top, bound at the foot of this file.
  Assumes zero-wait APB and a 4-cycle reset stretch.
*/
module pcsr_top_asserts #(
  parameter logic [15:0] OUI_PART_ONE = 16'h0A5A,
  parameter logic [5:0] OUI_PART_TWO = 6'h15,
  parameter logic [5:0] MODEL_NUMBER = 6'h2A,
  parameter logic [3:0] REVISION_NUMBER = 4'h3,
  parameter int unsigned XCVR_RESET_CYCLES = 4
)
(
  input wire logic clk,
  input wire logic reset,
  input wire pcsr_pkg::pcsr_apb_req_t apbReq,
  input wire pcsr_pkg::pcsr_apb_rsp_t apbRsp,
  input wire pcsr_pkg::pcsr_xcvr_ctl_t xcvrCtl,
  input wire pcsr_pkg::pcsr_xcvr_sts_t xcvrSts,
  input wire logic irq
);
  import pcsr_pkg::*;
  logic acc;
  logic rd;
  logic wrCtl;
  logic [7:0] a;
  logic [15:0] d;
  assign a = apbReq.paddr;
  assign d = apbRsp.prdata[15:0];
  assign acc = apbReq.psel && apbReq.penable;
  assign rd = acc && !apbReq.pwrite;
  assign wrCtl = acc && apbReq.pwrite && a == 8'hB4;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----
  // Properties
  // ----
  a_upper_zero:
    assert property (rd |-> apbRsp.prdata[31:16] == 16'h0000) else $error("upper half set");
  a_bad_addr:
    assert property (acc |-> apbRsp.pslverr == !(a inside {8'hB4, 8'hB8, 8'hBC, 8'hC0,
      8'hE0, 8'hE4})) else $error("pslverr wrong");
  a_autoneg_masks:
    assert property (xcvrCtl.autonegEnable |-> !xcvrCtl.speed100 && !xcvrCtl.fullDuplex)
      else $error("speed or duplex not masked");
  a_status_fixed:
    assert property (rd && a == 8'hB8 |-> d[15:6] == 10'h1E0 && d[3] && d[0])
      else $error("status fixed bits wrong");
  a_ctl_reserved:
    assert property (rd && a == 8'hB4 |-> d[10] == 1'b0 && d[6:0] == 7'h00)
      else $error("control reserved bits set");
  a_ctl_write:
    assert property (wrCtl |=> {xcvrCtl.loopbackSel, xcvrCtl.autonegEnable, xcvrCtl.powerDown}
      == {$past(apbReq.pwdata[14]), $past(apbReq.pwdata[12:11])}
      && xcvrCtl.collisionTestEn == $past(apbReq.pwdata[7])) else $error("control not applied");
  a_reset_hold:
    assert property (wrCtl && apbReq.pwdata[15] |=> xcvrCtl.softReset [*4])
      else $error("soft reset too short");
  a_restart_clear:
    assert property (xcvrCtl.autonegRestart && xcvrSts.autonegRestarted && !wrCtl
      |=> !xcvrCtl.autonegRestart) else $error("restart not cleared");
  a_ident_high:
    assert property (rd && a == 8'hBC |-> d == OUI_PART_ONE) else $error("ident high wrong");
  a_ident_low:
    assert property (rd && a == 8'hC0 |-> d == {OUI_PART_TWO, MODEL_NUMBER, REVISION_NUMBER})
      else $error("ident low wrong");
  cover property (rd && a == 8'hB8 && d[4]);
  cover property ($fell(xcvrCtl.softReset));
  cover property ($rose(irq));
endmodule

bind pcsr_top pcsr_top_asserts #(.OUI_PART_ONE(OUI_PART_ONE), .OUI_PART_TWO(OUI_PART_TWO),
  .MODEL_NUMBER(MODEL_NUMBER), .REVISION_NUMBER(REVISION_NUMBER),
  .XCVR_RESET_CYCLES(XCVR_RESET_CYCLES)) pcsr_top_asserts_i (.clk(clk), .reset(reset),
  .apbReq(apbReq), .apbRsp(apbRsp), .xcvrCtl(xcvrCtl), .xcvrSts(xcvrSts), .irq(irq));

// *** dv/pcsr_top_tb.sv ***
/*
  Bench for pcsr_top: APB master tasks, one task per test.
  Assumes the checker binds itself to the design.
*/
module pcsr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcsr_pkg::*;
  // Arbitrary identifier values
  localparam logic [15:0] ID1 = 16'h0A5A;
  localparam logic [15:0] ID2 = 16'h56A3;
  logic clk;
  logic reset;
  pcsr_apb_req_t rq;
  pcsr_apb_rsp_t rs;
  pcsr_xcvr_ctl_t ctl;
  pcsr_xcvr_sts_t sts;
  logic irq;
  logic [31:0] x;
  int n;
  int n_fail = 0;
  int checks = 0;

  pcsr_top #(.OUI_PART_ONE(ID1), .OUI_PART_TWO(ID2[15:10]), .MODEL_NUMBER(ID2[9:4]),
    .REVISION_NUMBER(ID2[3:0]), .XCVR_RESET_CYCLES(4)) pcsr_top_i (.clk(clk), .reset(reset),
    .apbReq(rq), .apbRsp(rs), .xcvrCtl(ctl), .xcvrSts(sts), .irq(irq));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] wd);
    rq.paddr <= a;
    rq.pwrite <= w;
    rq.pwdata <= {16'h0000, wd};
    rq.psel <= 1'b1;
    @(posedge clk);
    rq.penable <= 1'b1;
    // The wait for pready ends at the first edge with rs.pready high
    do
    begin
      @(posedge clk);
    end
    while (rs.pready !== 1'b1);
    x = rs.prdata;
    rq.psel <= 1'b0;
    rq.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    xfer(a, 1'b0, 16'h0000);
    chk(x[15:0], e);
  endtask

  task automatic irqc(input logic e);
    chk({15'h0000, irq}, {15'h0000, e});
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    sts <= pcsr_xcvr_sts_t'(sts ^ m);
    @(posedge clk);
    sts <= pcsr_xcvr_sts_t'(sts ^ m);
  endtask

  task automatic t_regs();
    chk({8'h00, ctl}, 16'h0010);
    rdc(8'hB4, 16'h3000);
    rdc(8'hB8, 16'h7809);
    rdc(8'hBC, ID1);
    wr(8'hC0, 16'hFFFF);
    rdc(8'hC0, ID2);
    wr(8'hC4, 16'hFFFF);
    rdc(8'hC4, 16'h0000);
    $display("regs test done");
  endtask

  task automatic t_ctl();
    wr(8'hB4, 16'h59FF);
    rdc(8'hB4, 16'h5980);
    chk({8'h00, ctl}, 16'h0059);
    wr(8'hB4, 16'h2100);
    chk({8'h00, ctl}, 16'h0022);
    wr(8'hB8, 16'h0000);
    rdc(8'hB8, 16'h7809);
    wr(8'hB4, 16'h1000);
    $display("control test done");
  endtask

  task automatic t_sreset();
    // Done already high, so only the stretcher holds the reset
    sts.resetDone <= 1'b1;
    wr(8'hB4, 16'h9000);
    rdc(8'hB4, 16'h9000);
    chk({15'h0000, ctl.softReset}, 16'h0001);
    n = 0;
    do
    begin
      xfer(8'hB4, 1'b0, 16'h0000);
      n++;
    end
    while (x[15] !== 1'b0 && n < 20);
    sts.resetDone <= 1'b0;
    chk(x[15:0], 16'h1000);
    $display("soft reset test done");
  endtask

  task automatic t_restart();
    wr(8'hB4, 16'h1200);
    chk({15'h0000, ctl.autonegRestart}, 16'h0001);
    pulse(6'b010000);
    rdc(8'hB4, 16'h1000);
    $display("restart test done");
  endtask

  task automatic t_events();
    wr(8'hE4, 16'h000F);
    rdc(8'hE4, 16'h000F);
    sts <= pcsr_xcvr_sts_t'(6'b001010);
    pulse(6'b000101);
    rdc(8'hB8, 16'h783B);
    rdc(8'hB8, 16'h782D);
    pulse(6'b000010);
    rdc(8'hB8, 16'h7829);
    rdc(8'hB8, 16'h782D);
    irqc(1'b1);
    rdc(8'hE0, 16'h000F);
    wr(8'hE0, 16'h000F);
    irqc(1'b0);
    wr(8'hE4, 16'h0000);
    pulse(6'b000001);
    rdc(8'hE0, 16'h0008);
    irqc(1'b0);
    wr(8'hE4, 16'h0008);
    irqc(1'b1);
    wr(8'hE0, 16'h0008);
    irqc(1'b0);
    $display("event test done");
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    reset = 1'b1;
    rq = '0;
    sts = '0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_ctl();
    t_sreset();
    t_restart();
    t_events();
    wrap_up();
  end
endmodule
